// ---- logic/tsc_pkg.sv ----
// Shared constants for the channel status and channel 1 compensation block.
// Assumes a 25 MHz system clock and a two-wire management bus as the only register path.
// ----------------------------------------------------------------------------
// Behaviour
// - Set overtemp status bit 3 when channel 4 reading exceeds its limit.
// - Set overtemp status bit 0 when channel 1 reading exceeds its limit.
// - Fault status bits 4..1 flag open or supply-tied diodes, channels 4..1.
// - Fault status bits 6 and 5 read 0 after reset, 1 once the first channel has been handled.
// - Configuration-one bit 3 enables channel 1 series-resistance cancellation.
// - Cancellation lengthens the channel 1 conversion by 125 ms.
// - Beta compensation starts enabled; clearing configuration-one bit 2 disables it.
// - Cancellation covers series resistance from 0 to 100 ohms.
// - Configuration-one bits 3 and 2 reset to 1.
// - Channels flagged as faulty are skipped by the measurement sequence.
// - Overtemp mask bits keep channels 4 and 1 off the overtemp output.
// ----------------------------------------------------------------------------
package tsc_pkg;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CONV_TIME_MS = 100;
  localparam int unsigned RC_EXTRA_MS = 125;
  localparam int unsigned CONV_CYCLES = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned RC_EXTRA_CYCLES = RC_EXTRA_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 24;
  localparam int unsigned NCH = 4;

  // ----------------------------------------------------------------------------
  // Bus address and register offsets
  // ----------------------------------------------------------------------------
  localparam logic [6:0] SMB_ADDR = 7'h4D;
  localparam logic [7:0] REG_LIMIT1 = 8'h11;
  localparam logic [7:0] REG_LIMIT4 = 8'h14;
  localparam logic [7:0] REG_CONFIG1 = 8'h41;
  localparam logic [7:0] REG_CONFIG3 = 8'h42;
  localparam logic [7:0] REG_OT_STATUS = 8'h45;
  localparam logic [7:0] REG_FAULT_STATUS = 8'h46;

  // ----------------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------------
  localparam int unsigned CFG1_RC_BIT = 3;
  localparam int unsigned CFG1_BETA_BIT = 2;
  localparam int unsigned CFG3_MASK4_BIT = 3;
  localparam int unsigned CFG3_MASK1_BIT = 0;
  localparam int unsigned OT_CH4_BIT = 3;
  localparam int unsigned OT_CH1_BIT = 0;
  localparam int unsigned FAULT_LSB = 1;
  localparam int unsigned UNUSED_LO_BIT = 5;
  localparam int unsigned UNUSED_HI_BIT = 6;
  localparam logic [7:0] CFG1_RESET = 8'h0C;
  localparam logic [7:0] CFG1_WMASK = 8'h0C;
  localparam logic [7:0] CFG3_RESET = 8'h00;
  localparam logic [7:0] CFG3_WMASK = 8'h09;
  localparam logic [7:0] LIMIT_RESET = 8'h7F;
  localparam logic [6:0] RSER_MAX_OHM = 7'h64;

endpackage

// ---- logic/tsc_conv_seq.sv ----
// Round-robin conversion sequencer for the four remote channels.
// Assumes fault inputs are already synchronised to i_clock.
`timescale 1ns/10ps
module tsc_conv_seq #(
  parameter int unsigned P_CONV_CYCLES = tsc_pkg::CONV_CYCLES,
  parameter int unsigned P_RC_EXTRA_CYCLES = tsc_pkg::RC_EXTRA_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_fault,
  input wire logic i_rc_en,
  output logic o_conv_active,
  output logic [1:0] o_conv_ch,
  output logic o_done,
  output logic [1:0] o_done_ch,
  output logic o_done_fault
);

  typedef enum logic {SEQ_CHECK, SEQ_CONV} tsc_seq_e;

  tsc_seq_e state_q;
  logic [1:0] ch_q;
  logic [tsc_pkg::CNT_W-1:0] cnt_q;
  logic done_q;
  logic [1:0] done_ch_q;
  logic fault_q;

  // Length is fixed at the start; a later config change applies to the next pass
  function automatic logic [tsc_pkg::CNT_W-1:0] conv_len(input logic [1:0] ch, input logic rc);
    logic [tsc_pkg::CNT_W-1:0] len;
    len = tsc_pkg::CNT_W'(P_CONV_CYCLES);
    if (ch == 2'h0 && rc) begin
      len = tsc_pkg::CNT_W'(P_CONV_CYCLES + P_RC_EXTRA_CYCLES);
    end
    return len;
  endfunction

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_q <= SEQ_CHECK;
      ch_q <= 2'h0;
      cnt_q <= '0;
      done_q <= 1'b0;
      done_ch_q <= 2'h0;
      fault_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        SEQ_CHECK: begin
          if (i_fault[ch_q]) begin
            done_q <= 1'b1;
            fault_q <= 1'b1;
            done_ch_q <= ch_q;
            ch_q <= ch_q + 2'h1;
          end else begin
            cnt_q <= conv_len(ch_q, i_rc_en);
            state_q <= SEQ_CONV;
          end
        end
        SEQ_CONV: begin
          if (cnt_q <= tsc_pkg::CNT_W'(1)) begin
            done_q <= 1'b1;
            fault_q <= 1'b0;
            done_ch_q <= ch_q;
            ch_q <= ch_q + 2'h1;
            state_q <= SEQ_CHECK;
          end else begin
            cnt_q <= cnt_q - tsc_pkg::CNT_W'(1);
          end
        end
        default: state_q <= SEQ_CHECK;
      endcase
    end
  end

  assign o_conv_active = (state_q == SEQ_CONV);
  assign o_conv_ch = ch_q;
  assign o_done = done_q;
  assign o_done_ch = done_ch_q;
  assign o_done_fault = fault_q;

endmodule

// ---- logic/tsc_status_comp.sv ----
// Two-wire register slave, channel status flags, overtemp output and channel 1 compensation controls.
// Assumes bus and diode fault pins are asynchronous; ADC readings arrive in the i_clock domain.
`timescale 1ns/10ps
module tsc_status_comp #(
  parameter int unsigned P_CONV_CYCLES = tsc_pkg::CONV_CYCLES,
  parameter int unsigned P_RC_EXTRA_CYCLES = tsc_pkg::RC_EXTRA_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_smb_clk,
  input wire logic i_smb_data,
  output logic o_smb_data,
  output logic o_smb_data_oe,
  input wire logic [3:0] i_ch_fault_raw,
  input wire logic [7:0] i_ch1_temp,
  input wire logic [7:0] i_ch4_temp,
  input wire logic [6:0] i_ch1_rser_est,
  output logic o_conv_active,
  output logic [1:0] o_conv_ch,
  output logic o_ch1_rc_en,
  output logic o_ch1_beta_en,
  output logic [6:0] o_ch1_rser_cancel,
  output logic o_overtemp_output,
  output logic o_overtemp_output_oe
);

  typedef enum logic [3:0] {
    SMB_IDLE, SMB_ADDR, SMB_AACK, SMB_CMD, SMB_CACK, SMB_WDATA, SMB_WACK, SMB_RDATA, SMB_RACK
  } tsc_smb_e;

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic [3:0] fault_s1, fault_s2;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= i_smb_clk;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= i_smb_data;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      fault_s1 <= 4'h0;
      fault_s2 <= 4'h0;
    end else begin
      fault_s1 <= i_ch_fault_raw;
      fault_s2 <= fault_s1;
    end
  end

  logic bus_start, bus_stop, scl_rise, scl_fall;
  assign bus_start = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign bus_stop = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  assign scl_rise = scl_s2 && !scl_s3;
  assign scl_fall = !scl_s2 && scl_s3;

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic [7:0] cfg1_q, cfg3_q, limit1_q, limit4_q;
  logic [7:0] ot_status_q, fault_status_q;
  logic [7:0] ptr_q, wr_data_q;
  logic wr_stb_q;

  function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] c1, input logic [7:0] c3,
                                          input logic [7:0] l1, input logic [7:0] l4, input logic [7:0] ot,
                                          input logic [7:0] ft);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      tsc_pkg::REG_CONFIG1: v = c1;
      tsc_pkg::REG_CONFIG3: v = c3;
      tsc_pkg::REG_LIMIT1: v = l1;
      tsc_pkg::REG_LIMIT4: v = l4;
      tsc_pkg::REG_OT_STATUS: v = ot;
      tsc_pkg::REG_FAULT_STATUS: v = ft;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Only implemented configuration bits are stored; the rest read back as zero
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      cfg1_q <= tsc_pkg::CFG1_RESET;
      cfg3_q <= tsc_pkg::CFG3_RESET;
      limit1_q <= tsc_pkg::LIMIT_RESET;
      limit4_q <= tsc_pkg::LIMIT_RESET;
    end else if (wr_stb_q) begin
      case (ptr_q)
        tsc_pkg::REG_CONFIG1: cfg1_q <= wr_data_q & tsc_pkg::CFG1_WMASK;
        tsc_pkg::REG_CONFIG3: cfg3_q <= wr_data_q & tsc_pkg::CFG3_WMASK;
        tsc_pkg::REG_LIMIT1: limit1_q <= wr_data_q;
        tsc_pkg::REG_LIMIT4: limit4_q <= wr_data_q;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Bus slave: write byte, send byte, read byte, receive byte
  // ----------------------------------------------------------------------------
  tsc_smb_e smb_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q, rd_q, rd_now;
  logic rw_q, sda_oe_q;

  assign rd_now = reg_read(ptr_q, cfg1_q, cfg3_q, limit1_q, limit4_q, ot_status_q, fault_status_q);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      smb_q <= SMB_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      rd_q <= 8'h00;
      ptr_q <= 8'h00;
      wr_data_q <= 8'h00;
      wr_stb_q <= 1'b0;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      if (bus_start) begin
        smb_q <= SMB_ADDR;
        bit_cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (bus_stop) begin
        smb_q <= SMB_IDLE;
        sda_oe_q <= 1'b0;
      end else if (scl_rise) begin
        case (smb_q)
          SMB_ADDR, SMB_CMD, SMB_WDATA: begin
            shift_q <= {shift_q[6:0], sda_s2};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          SMB_RDATA: bit_cnt_q <= bit_cnt_q + 4'h1;
          SMB_RACK: begin
            bit_cnt_q <= 4'h0;
            if (sda_s2) begin
              smb_q <= SMB_IDLE;
            end else begin
              rd_q <= rd_now;
              smb_q <= SMB_RDATA;
            end
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (smb_q)
          SMB_ADDR: begin
            if (bit_cnt_q == 4'h8) begin
              if (shift_q[7:1] == tsc_pkg::SMB_ADDR) begin
                rw_q <= shift_q[0];
                sda_oe_q <= 1'b1;
                smb_q <= SMB_AACK;
              end else begin
                smb_q <= SMB_IDLE;
              end
            end
          end
          SMB_AACK: begin
            bit_cnt_q <= 4'h0;
            if (rw_q) begin
              rd_q <= rd_now;
              sda_oe_q <= ~rd_now[7];
              smb_q <= SMB_RDATA;
            end else begin
              sda_oe_q <= 1'b0;
              smb_q <= SMB_CMD;
            end
          end
          SMB_CMD: begin
            if (bit_cnt_q == 4'h8) begin
              ptr_q <= shift_q;
              sda_oe_q <= 1'b1;
              smb_q <= SMB_CACK;
            end
          end
          SMB_WDATA: begin
            if (bit_cnt_q == 4'h8) begin
              wr_data_q <= shift_q;
              wr_stb_q <= 1'b1;
              sda_oe_q <= 1'b1;
              smb_q <= SMB_WACK;
            end
          end
          SMB_CACK, SMB_WACK: begin
            sda_oe_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            smb_q <= SMB_WDATA;
          end
          SMB_RDATA: begin
            if (bit_cnt_q == 4'h8) begin
              sda_oe_q <= 1'b0;
              smb_q <= SMB_RACK;
            end else begin
              sda_oe_q <= ~rd_q[3'(4'h7 - bit_cnt_q)];
            end
          end
          default: ;
        endcase
      end
    end
  end

  assign o_smb_data = 1'b0;
  assign o_smb_data_oe = sda_oe_q;

  // ----------------------------------------------------------------------------
  // Conversion sequencing and status flags
  // ----------------------------------------------------------------------------
  logic seq_done, seq_fault;
  logic [1:0] seq_ch;
  logic seen_conv_q;

  tsc_conv_seq #(
    .P_CONV_CYCLES(P_CONV_CYCLES),
    .P_RC_EXTRA_CYCLES(P_RC_EXTRA_CYCLES)
  ) u_seq (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_fault(fault_s2),
    .i_rc_en(cfg1_q[tsc_pkg::CFG1_RC_BIT]),
    .o_conv_active(o_conv_active),
    .o_conv_ch(o_conv_ch),
    .o_done(seq_done),
    .o_done_ch(seq_ch),
    .o_done_fault(seq_fault)
  );

  // Readings are two's complement; a faulted channel cannot flag overtemp
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ot_status_q <= 8'h00;
      fault_status_q <= 8'h00;
      seen_conv_q <= 1'b0;
    end else begin
      fault_status_q[tsc_pkg::UNUSED_HI_BIT] <= seen_conv_q;
      fault_status_q[tsc_pkg::UNUSED_LO_BIT] <= seen_conv_q;
      fault_status_q[7] <= 1'b0;
      fault_status_q[0] <= 1'b0;
      ot_status_q[7:4] <= 4'h0;
      ot_status_q[2:1] <= 2'h0;
      if (seq_done) begin
        seen_conv_q <= 1'b1;
        fault_status_q[tsc_pkg::FAULT_LSB + 32'(seq_ch)] <= seq_fault;
        if (seq_ch == 2'h0) begin
          ot_status_q[tsc_pkg::OT_CH1_BIT] <= !seq_fault && ($signed(i_ch1_temp) > $signed(limit1_q));
        end
        if (seq_ch == 2'h3) begin
          ot_status_q[tsc_pkg::OT_CH4_BIT] <= !seq_fault && ($signed(i_ch4_temp) > $signed(limit4_q));
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs and channel 1 compensation
  // ----------------------------------------------------------------------------
  logic ot_drive_q, rc_en_q, beta_en_q;
  logic [6:0] rser_q;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ot_drive_q <= 1'b0;
      rc_en_q <= 1'b0;
      beta_en_q <= 1'b0;
      rser_q <= 7'h00;
    end else begin
      ot_drive_q <= (ot_status_q[tsc_pkg::OT_CH1_BIT] && !cfg3_q[tsc_pkg::CFG3_MASK1_BIT]) ||
                    (ot_status_q[tsc_pkg::OT_CH4_BIT] && !cfg3_q[tsc_pkg::CFG3_MASK4_BIT]);
      rc_en_q <= cfg1_q[tsc_pkg::CFG1_RC_BIT];
      beta_en_q <= cfg1_q[tsc_pkg::CFG1_BETA_BIT];
      // Estimates past the range saturate rather than wrap
      if (!cfg1_q[tsc_pkg::CFG1_RC_BIT]) begin
        rser_q <= 7'h00;
      end else if (i_ch1_rser_est > tsc_pkg::RSER_MAX_OHM) begin
        rser_q <= tsc_pkg::RSER_MAX_OHM;
      end else begin
        rser_q <= i_ch1_rser_est;
      end
    end
  end

  assign o_overtemp_output = 1'b0;
  assign o_overtemp_output_oe = ot_drive_q;
  assign o_ch1_rc_en = rc_en_q;
  assign o_ch1_beta_en = beta_en_q;
  assign o_ch1_rser_cancel = rser_q;

endmodule

// ---- bench/tsc_props.sv ----
// Checker of top ports: channel sequencing and channel 1 compensation.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/10ps
module tsc_props #(
  parameter int unsigned P_CONV_CYCLES = 20,
  parameter int unsigned P_RC_EXTRA_CYCLES = 25
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_smb_clk,
  input wire logic [6:0] i_ch1_rser_est,
  input wire logic o_smb_data,
  input wire logic o_conv_active,
  input wire logic [1:0] o_conv_ch,
  input wire logic o_ch1_rc_en,
  input wire logic o_ch1_beta_en,
  input wire logic [6:0] o_ch1_rser_cancel,
  input wire logic o_overtemp_output
);
  // ------------------
  // Segment length
  // ------------------
  logic [23:0] cnt_q;
  logic [1:0] ch_q;
  logic rc_q;
  logic seg_start;
  logic [23:0] exp_len;
  assign seg_start = o_conv_active && (cnt_q == 24'h0 || o_conv_ch != ch_q);
  // Cancellation is judged at segment start; a config write on that exact cycle is not modelled
  assign exp_len = 24'(P_CONV_CYCLES) + ((ch_q == 2'h0 && rc_q) ? 24'(P_RC_EXTRA_CYCLES) : 24'h0);
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      cnt_q <= 24'h0;
    end else begin
      cnt_q <= seg_start ? 24'h1 : (o_conv_active ? cnt_q + 24'h1 : 24'h0);
    end
  end
  always_ff @(posedge i_clock) begin
    ch_q <= o_conv_ch;
    if (seg_start) begin
      rc_q <= o_ch1_rc_en;
    end
  end
  // ------------------
  // Properties
  // ------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_conv_length: assert property (cnt_q != 24'h0 && (!o_conv_active || o_conv_ch != ch_q) |-> cnt_q == exp_len)
    else $error("conversion length wrong");
  a_ch_order: assert property ($changed(o_conv_ch) |-> o_conv_ch == $past(o_conv_ch) + 2'h1)
    else $error("channel order wrong");
  a_comp_reset_on: assert property ($fell(i_sys_rst) |=> o_ch1_rc_en && o_ch1_beta_en)
    else $error("compensation off after reset");
  a_comp_by_bus: assert property (!$past(i_sys_rst, 2) && $changed({o_ch1_rc_en, o_ch1_beta_en}) |-> !i_smb_clk)
    else $error("compensation changed outside a write");
  a_rser_follow: assert property (o_ch1_rc_en && $past(o_ch1_rc_en) |->
    o_ch1_rser_cancel == (($past(i_ch1_rser_est) > 7'h64) ? 7'h64 : $past(i_ch1_rser_est)))
    else $error("cancel value wrong");
  a_rser_off: assert property (!o_ch1_rc_en && !$past(o_ch1_rc_en) |-> o_ch1_rser_cancel == 7'h00)
    else $error("cancel active while disabled");
  a_rser_ceiling: assert property (o_ch1_rser_cancel <= 7'h64)
    else $error("cancel above range");
  a_od_values: assert property (o_smb_data == 1'b0 && o_overtemp_output == 1'b0)
    else $error("open-drain value not low");
endmodule

bind tsc_status_comp tsc_props #(
  .P_CONV_CYCLES(P_CONV_CYCLES),
  .P_RC_EXTRA_CYCLES(P_RC_EXTRA_CYCLES)
) u_props (
  .i_clock(i_clock),
  .i_sys_rst(i_sys_rst),
  .i_smb_clk(i_smb_clk),
  .i_ch1_rser_est(i_ch1_rser_est),
  .o_smb_data(o_smb_data),
  .o_conv_active(o_conv_active),
  .o_conv_ch(o_conv_ch),
  .o_ch1_rc_en(o_ch1_rc_en),
  .o_ch1_beta_en(o_ch1_beta_en),
  .o_ch1_rser_cancel(o_ch1_rser_cancel),
  .o_overtemp_output(o_overtemp_output)
);

// ---- bench/tsc_host_model.sv ----
// Two-wire bus host driving the block's register port.
// Assumes an open-drain data wire with pull-up; all changes at falling clock edges.
`timescale 1ns/10ps
module tsc_host_model #(
  parameter int unsigned P_HALF = 6
) (
  input wire logic i_clock,
  input wire logic i_dev_pull,
  output logic o_scl,
  output logic o_sda
);
  // ------------------
  // Bit and byte level
  // ------------------
  logic sda_drv = 1'b1;
  initial o_scl = 1'b1;
  // Released wire floats high through the pull-up
  assign o_sda = sda_drv & ~i_dev_pull;
  task automatic gap();
    repeat (P_HALF) @(negedge i_clock);
  endtask
  task automatic clk_bit(input logic b, output logic s);
    @(negedge i_clock);
    sda_drv = b;
    gap();
    o_scl = 1'b1;
    gap();
    s = o_sda;
    o_scl = 1'b0;
  endtask
  task automatic start();
    @(negedge i_clock);
    sda_drv = 1'b1;
    gap();
    o_scl = 1'b1;
    gap();
    sda_drv = 1'b0;
    gap();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    @(negedge i_clock);
    sda_drv = 1'b0;
    gap();
    o_scl = 1'b1;
    gap();
    sda_drv = 1'b1;
    gap();
  endtask
  task automatic tx(input logic [7:0] d, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, s);
    ok = ok & ~s;
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d, output logic ok);
    logic [7:0] w;
    w = d;
    if (r == tsc_pkg::REG_CONFIG1 && d[2]) w[3] = 1'b1;
    ok = 1'b1;
    start();
    tx({tsc_pkg::SMB_ADDR, 1'b0}, ok);
    tx(r, ok);
    tx(w, ok);
    stop();
  endtask
  task automatic rd(input logic [7:0] r, output logic [7:0] d, output logic ok);
    logic s;
    ok = 1'b1;
    start();
    tx({tsc_pkg::SMB_ADDR, 1'b0}, ok);
    tx(r, ok);
    start();
    tx({tsc_pkg::SMB_ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(1'b1, s);
    stop();
  endtask
endmodule

// ---- bench/tb_temp_status_and_ch1_compensation.sv ----
// Self-checking bench for the status and channel 1 compensation block.
// Assumes the host model and the bound checker; short conversion counts.
`timescale 1ns/10ps
module tb_temp_status_and_ch1_compensation;
  // ------------------
  // Harness
  // ------------------
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic scl, sda, dev_oe, ot_oe, act, rc_en, beta_en, watch = 1'b0;
  logic [1:0] ch;
  logic [3:0] fault = 4'h0;
  logic [7:0] t1 = 8'h00, t4 = 8'h00;
  logic [6:0] est = 7'h00, rser;
  int bad_count = 0, checked = 0, cyc = 0, skip_hits = 0;
  always #20 i_clock = ~i_clock;
  tsc_status_comp #(.P_CONV_CYCLES(800), .P_RC_EXTRA_CYCLES(1000)) u_dut (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_smb_clk(scl), .i_smb_data(sda), .o_smb_data(), .o_smb_data_oe(dev_oe),
    .i_ch_fault_raw(fault), .i_ch1_temp(t1), .i_ch4_temp(t4), .i_ch1_rser_est(est), .o_conv_active(act),
    .o_conv_ch(ch), .o_ch1_rc_en(rc_en), .o_ch1_beta_en(beta_en), .o_ch1_rser_cancel(rser),
    .o_overtemp_output(), .o_overtemp_output_oe(ot_oe));
  tsc_host_model u_host (.i_clock(i_clock), .i_dev_pull(dev_oe), .o_scl(scl), .o_sda(sda));
  always @(negedge i_clock) if (watch && act === 1'b1 && fault[ch] === 1'b1) skip_hits++;
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    logic ok;
    u_host.wr(r, d, ok);
    chk("write ack", {7'h0, ok}, 8'h01);
  endtask
  task automatic rd(input logic [7:0] r, input logic [7:0] exp, input string what);
    logic [7:0] d;
    logic ok;
    u_host.rd(r, d, ok);
    chk("read ack", {7'h0, ok}, 8'h01);
    chk(what, d, exp);
  endtask
  // Returns just after channel 4 has been handled
  task automatic wait_round();
    int n;
    n = 0;
    while (ch !== 2'h3 && n < 9000) begin
      @(negedge i_clock);
      n++;
    end
    while (ch !== 2'h0 && n < 9000) begin
      @(negedge i_clock);
      n++;
    end
    repeat (4) @(negedge i_clock);
  endtask
  function automatic logic [7:0] exp_ot(input logic [7:0] a1, l1, a4, l4, input logic [3:0] f);
    exp_ot = 8'h00;
    exp_ot[0] = !f[0] && ($signed(a1) > $signed(l1));
    exp_ot[3] = !f[3] && ($signed(a4) > $signed(l4));
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ------------------
  // Tests
  // ------------------
  initial begin
    logic [7:0] l1, l4, m, e;
    logic [3:0] f;
    // Beta off alone stands for a discrete sensor; beta is never left enabled without cancellation
    logic [7:0] cfg_tab [4] = '{8'h00, 8'h08, 8'hFF, 8'h0C};
    logic [39:0] corner [2] = '{{8'h19, 8'h19, 8'h80, 8'h7F, 8'h00}, {8'h1A, 8'h19, 8'h00, 8'hFF, 8'h01}};
    void'($urandom(7));
    repeat (10) @(negedge i_clock);
    i_sys_rst = 1'b0;
    rd(tsc_pkg::REG_FAULT_STATUS, 8'h00, "fault at reset");
    rd(tsc_pkg::REG_OT_STATUS, 8'h00, "overtemp at reset");
    rd(tsc_pkg::REG_CONFIG1, 8'h0C, "config1 at reset");
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      est = (i == 2) ? 7'h7F : 7'($urandom_range(127));
      wr(tsc_pkg::REG_CONFIG1, cfg_tab[i]);
      repeat (3) @(negedge i_clock);
      rd(tsc_pkg::REG_CONFIG1, cfg_tab[i] & 8'h0C, "config1");
      chk("rc enable", {7'h0, rc_en}, {7'h0, cfg_tab[i][3]});
      chk("beta enable", {7'h0, beta_en}, {7'h0, cfg_tab[i][2]});
      chk("cancel", {1'b0, rser}, {1'b0, cfg_tab[i][3] ? ((est > 7'h64) ? 7'h64 : est) : 7'h00});
    end
    $display("test compensation done");
    wr(tsc_pkg::REG_OT_STATUS, 8'hFF);
    rd(tsc_pkg::REG_OT_STATUS, 8'h00, "status after write");
    rd(8'h7E, 8'h00, "unmapped");
    $display("test read-only done");
    for (int i = 0; i < 4; i++) begin
      {t1, l1, t4, l4, m} = (i < 2) ? corner[i] : {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
      m = m & 8'h09;
      f = (i == 3) ? 4'($urandom_range(1, 14)) : 4'h0;
      fault = f;
      wr(tsc_pkg::REG_LIMIT1, l1);
      wr(tsc_pkg::REG_LIMIT4, l4);
      wr(tsc_pkg::REG_CONFIG3, m);
      wait_round();
      watch = 1'b1;
      wait_round();
      watch = 1'b0;
      e = exp_ot(t1, l1, t4, l4, f);
      rd(tsc_pkg::REG_OT_STATUS, e, "overtemp status");
      rd(tsc_pkg::REG_FAULT_STATUS, {3'b011, f, 1'b0}, "fault status");
      chk("overtemp pin", {7'h0, ot_oe}, {7'h0, |(e & ~m)});
      fault = 4'h0;
      $display("test overtemp case %0d done", i);
    end
    chk("skipped channel converted", 8'(skip_hits), 8'h00);
    wrap_up();
  end
endmodule
